// ---- rrs_pkg.sv ----
// Constants shared by the rotate/fill datapath: bus map, field positions, opcodes, resets.
// Assumes a single AHB-Lite master with 32-bit word accesses.
// How it works
// - Rotate through carry: bit0 to C, C to bit7.
// - Plain rotate: bit0 to bit7, carry untouched.
// - Destination bit zero: result goes to W.
// - Destination bit one: result back to file.
// - Access bit zero: access bank, bank ignored.
// - Access bit one: bank register picks the bank.
// - Extended set, access zero, f<=95: indexed offset.
// - One word; decode, read, process, write phases.
// - Fill writes all ones, flags unchanged.
package rrs_pkg;
    localparam logic [7:0]  ADDR_CTRL      = 8'h00;
    localparam logic [7:0]  ADDR_INSTR     = 8'h04;
    localparam logic [7:0]  ADDR_FLAGS     = 8'h08;
    localparam logic [7:0]  ADDR_WORK      = 8'h0C;
    localparam logic [7:0]  ADDR_BANK      = 8'h10;
    localparam logic [7:0]  ADDR_INDEX     = 8'h14;
    localparam logic [7:0]  ADDR_MEM_PTR   = 8'h18;
    localparam logic [7:0]  ADDR_MEM_DATA  = 8'h1C;
    localparam logic [7:0]  ADDR_STATE     = 8'h20;

    localparam int          CTRL_EXT_BIT   = 0;
    localparam int          FLAG_C_BIT     = 0;
    localparam int          FLAG_Z_BIT     = 1;
    localparam int          FLAG_N_BIT     = 2;
    localparam int          STATE_BUSY_BIT = 0;
    localparam int          STATE_ILL_BIT  = 1;

    localparam int          DEST_BIT       = 9;
    localparam int          ACCESS_BIT     = 8;
    localparam logic [5:0]  OPC_RRC        = 6'h0C;
    localparam logic [5:0]  OPC_RRN        = 6'h10;
    localparam logic [6:0]  OPC_FILL       = 7'h34;

    localparam logic [7:0]  INDEX_LIMIT    = 8'h5F;
    localparam logic [7:0]  ALL_ONES       = 8'hFF;
    localparam logic [3:0]  ACCESS_HI_BANK = 4'hF;
    localparam logic [3:0]  ACCESS_LO_BANK = 4'h0;

    localparam logic [1:0]  HTRANS_NONSEQ  = 2'h2;
    localparam logic        HRESP_OKAY     = 1'h0;
    localparam logic [31:0] RESET_WORD     = 32'h0000_0000;
    localparam logic [7:0]  RESET_BYTE     = 8'h00;
    localparam logic [15:0] RESET_INSTR    = 16'h0000;

    typedef enum logic [2:0] {
        RRS_IDLE,
        RRS_DECODE,
        RRS_READ,
        RRS_PROCESS,
        RRS_WRITE
    } rrs_phase_e;
endpackage : rrs_pkg

// ---- rrs_core.sv ----
// Rotate-right / fill-ones file-register datapath with its data memory and AHB-Lite slave.
// Assumes a zero-wait AHB-Lite master doing single 32-bit word transfers only.
//
// Decided for this implementation: register access over AHB-Lite and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
module rrs_core
    import rrs_pkg::*;
#(
    parameter int BANK_W = 4
) (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp
);
    localparam int AW    = BANK_W + 8;
    localparam int DEPTH = 1 << AW;

    logic [7:0]       mem [DEPTH];
    logic             ext_q;
    logic [15:0]      instr_q;
    logic [2:0]       flags_q;
    logic [7:0]       work_q;
    logic [BANK_W-1:0] bank_number_register_q;
    logic [AW-1:0]    index_q;
    logic [AW-1:0]    mem_ptr_q;
    logic             illegal_q;
    rrs_phase_e       phase_q;

    logic             wr_pend_q;
    logic [7:0]       wr_addr_q;
    logic [31:0]      hrdata_q;
    logic             hreadyout_q;
    logic             hresp_q;

    logic             rrc_op;
    logic             rrn_op;
    logic             fill_ones_op;
    logic [AW-1:0]    op_addr_q;
    logic [1:0]       kind_q;
    logic             dest_file_q;
    logic [7:0]       operand_q;
    logic [7:0]       result_q;
    logic             busy;
    logic             bus_access;
    logic             start;
    logic [AW-1:0]    eff_addr;
    logic [7:0]       f_field;

    assign hrdata    = hrdata_q;
    assign hreadyout = hreadyout_q;
    assign hresp     = hresp_q;

    assign busy       = (phase_q != RRS_IDLE);
    assign bus_access = hsel && hready && (htrans == HTRANS_NONSEQ);
    assign start      = wr_pend_q && (wr_addr_q == ADDR_INSTR) && !busy;
    assign f_field    = instr_q[7:0];

    // Opcode fields sit in the upper bits; d (rotates only) and a follow, then the 8-bit address.
    assign rrc_op       = (instr_q[15:10] == OPC_RRC);
    assign rrn_op       = (instr_q[15:10] == OPC_RRN);
    assign fill_ones_op = (instr_q[15:9] == OPC_FILL);

    // Every 8-bit f is legal; only the mapping to physical memory differs.
    always_comb begin
        if (instr_q[ACCESS_BIT]) begin
            eff_addr = {bank_number_register_q, f_field};
        end else if (ext_q && (f_field <= INDEX_LIMIT)) begin
            eff_addr = AW'(index_q + AW'(f_field));
        end else if (f_field <= INDEX_LIMIT) begin
            eff_addr = {BANK_W'(ACCESS_LO_BANK), f_field};
        end else begin
            eff_addr = {BANK_W'(ACCESS_HI_BANK), f_field};
        end
    end

    // Bus front end: ready from the first edge after reset, always OKAY; writes land in the data phase.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout_q <= 1'b0;
            hresp_q     <= HRESP_OKAY;
            wr_pend_q   <= 1'b0;
            wr_addr_q   <= RESET_BYTE;
        end else begin
            hreadyout_q <= 1'b1;
            hresp_q     <= HRESP_OKAY;
            wr_pend_q   <= bus_access && hwrite;
            wr_addr_q   <= haddr[7:0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata_q <= RESET_WORD;
        end else if (bus_access && !hwrite) begin
            case (haddr[7:0])
                ADDR_CTRL:     hrdata_q <= 32'(ext_q);
                ADDR_INSTR:    hrdata_q <= 32'(instr_q);
                ADDR_FLAGS:    hrdata_q <= 32'(flags_q);
                ADDR_WORK:     hrdata_q <= 32'(work_q);
                ADDR_BANK:     hrdata_q <= 32'(bank_number_register_q);
                ADDR_INDEX:    hrdata_q <= 32'(index_q);
                ADDR_MEM_PTR:  hrdata_q <= 32'(mem_ptr_q);
                ADDR_MEM_DATA: hrdata_q <= 32'(mem[mem_ptr_q]);
                ADDR_STATE:    hrdata_q <= 32'({illegal_q, busy});
                default:       hrdata_q <= RESET_WORD;
            endcase
        end
    end

    // Software-owned settings; bank and index are frozen while an instruction runs, CTRL and the memory pointer are not.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ext_q                  <= 1'b0;
            bank_number_register_q <= '0;
            index_q                <= '0;
            mem_ptr_q              <= '0;
        end else if (wr_pend_q) begin
            case (wr_addr_q)
                ADDR_CTRL:    ext_q <= hwdata[CTRL_EXT_BIT];
                ADDR_BANK:    if (!busy) bank_number_register_q <= hwdata[BANK_W-1:0];
                ADDR_INDEX:   if (!busy) index_q <= hwdata[AW-1:0];
                ADDR_MEM_PTR: mem_ptr_q <= hwdata[AW-1:0];
                default:      ;
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            instr_q <= RESET_INSTR;
        end else if (start) begin
            instr_q <= hwdata[15:0];
        end
    end

    // One instruction word walks decode, read, process and write, one phase per clock.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            phase_q     <= RRS_IDLE;
            illegal_q   <= 1'b0;
            op_addr_q   <= '0;
            kind_q      <= 2'h0;
            dest_file_q <= 1'b0;
            operand_q   <= RESET_BYTE;
        end else begin
            case (phase_q)
                RRS_IDLE: begin
                    if (start) begin
                        phase_q <= RRS_DECODE;
                    end
                end
                RRS_DECODE: begin
                    op_addr_q <= eff_addr;
                    if (rrc_op || rrn_op || fill_ones_op) begin
                        illegal_q   <= 1'b0;
                        kind_q      <= {fill_ones_op, rrc_op};
                        dest_file_q <= fill_ones_op || instr_q[DEST_BIT];
                        phase_q     <= RRS_READ;
                    end else begin
                        illegal_q <= 1'b1;
                        phase_q   <= RRS_IDLE;
                    end
                end
                RRS_READ: begin
                    operand_q <= mem[op_addr_q];
                    phase_q   <= RRS_PROCESS;
                end
                RRS_PROCESS: phase_q <= RRS_WRITE;
                RRS_WRITE:   phase_q <= RRS_IDLE;
                default:     phase_q <= RRS_IDLE;
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            result_q <= RESET_BYTE;
        end else if (phase_q == RRS_PROCESS) begin
            case (kind_q)
                2'h1:    result_q <= {flags_q[FLAG_C_BIT], operand_q[7:1]};
                2'h0:    result_q <= {operand_q[0], operand_q[7:1]};
                default: result_q <= ALL_ONES;
            endcase
        end
    end

    // Fill leaves all flags alone; the plain rotate never touches carry.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            flags_q <= 3'h0;
        end else if (phase_q == RRS_WRITE && kind_q != 2'h2) begin
            flags_q[FLAG_N_BIT] <= result_q[7];
            flags_q[FLAG_Z_BIT] <= (result_q == RESET_BYTE);
            if (kind_q == 2'h1) begin
                flags_q[FLAG_C_BIT] <= operand_q[0];
            end
        end else if (wr_pend_q && wr_addr_q == ADDR_FLAGS && !busy) begin
            flags_q <= hwdata[2:0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            work_q <= RESET_BYTE;
        end else if (phase_q == RRS_WRITE && !dest_file_q) begin
            work_q <= result_q;
        end else if (wr_pend_q && wr_addr_q == ADDR_WORK && !busy) begin
            work_q <= hwdata[7:0];
        end
    end

    // Memory has no reset so it maps onto plain RAM; bus writes made while busy are dropped.
    always_ff @(posedge hclk) begin
        if (phase_q == RRS_WRITE && dest_file_q) begin
            mem[op_addr_q] <= result_q;
        end else if (wr_pend_q && wr_addr_q == ADDR_MEM_DATA && !busy) begin
            mem[mem_ptr_q] <= hwdata[7:0];
        end
    end

    logic unused_ok;
    assign unused_ok = &{1'b0, hsize, haddr[31:8], hwdata[31:16]};
endmodule : rrs_core
`default_nettype wire

// ---- rrs_monitor.sv ----
// Bus-side checker for rrs_core, bound to its AHB-Lite slave port.
// Assumes one master that makes only single word transfers.
`timescale 1ns/1ns
`default_nettype none
module rrs_monitor
    import rrs_pkg::*;
(
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [31:0] hwdata,
    input wire logic        hready,
    input wire logic [31:0] hrdata,
    input wire logic        hreadyout,
    input wire logic        hresp
);
    logic       ap;
    logic       rd_q;
    logic [7:0] ad_q;
    assign ap = hsel && hready && htrans == HTRANS_NONSEQ;
    always_ff @(posedge hclk) begin
        rd_q <= ap && !hwrite;
        ad_q <= haddr[7:0];
    end
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    sequence rot_start;
        ap && hwrite && haddr[7:0] == ADDR_INSTR
        ##1 (hwdata[15:10] == OPC_RRC || hwdata[15:10] == OPC_RRN);
    endsequence
    sequence state_rd;
        ap && !hwrite && haddr[7:0] == ADDR_STATE;
    endsequence
    a_resp_okay: assert property (hresp == HRESP_OKAY)
        else $error("slave answered other than OKAY");
    a_ready_up: assert property ($past(hresetn) |-> hreadyout)
        else $error("hreadyout low after reset");
    a_rdata_hold: assert property ($changed(hrdata) |-> rd_q)
        else $error("read data moved without a read");
    // Busy is seen by state reads whose address phase falls one to four edges after
    // the instruction's data phase; the fifth edge already finds the core idle.
    a_busy_on: assert property (rot_start ##[1:4] state_rd |=> hrdata[0])
        else $error("busy missing inside the instruction");
    a_busy_off: assert property (rot_start ##[6:8] state_rd |=> !hrdata[0])
        else $error("busy still set after the instruction");
    a_work_byte: assert property (rd_q && ad_q == ADDR_WORK |-> hrdata[31:8] == 24'h0)
        else $error("working register wider than a byte");
    a_bank_width: assert property (rd_q && ad_q == ADDR_BANK |-> hrdata[31:4] == 28'h0)
        else $error("bank register too wide");
    a_flag_width: assert property (rd_q && ad_q == ADDR_FLAGS |-> hrdata[31:3] == 29'h0)
        else $error("flag register too wide");
endmodule : rrs_monitor
bind rrs_core rrs_monitor rrs_monitor_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp));
`default_nettype wire

// ---- rotate_right_and_set_file_ops_test.sv ----
// Self-checking bench for rrs_core, driving its AHB-Lite slave port directly.
// Assumes the slave never stalls for long; every wait is cut by the cycle ceiling.
`timescale 1ns/1ns
`default_nettype none
module rotate_right_and_set_file_ops_test
    import rrs_pkg::*;
;
    logic        hclk = 1'b0;
    logic        hresetn = 1'b0;
    logic        hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    int          fail_count = 0;
    int          samples_checked = 0;
    int          cycles = 0;
    logic [31:0] q;
    rrs_core rrs_core_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp));
    initial forever #20 hclk = ~hclk;
    task automatic final_report();
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : final_report
    always @(posedge hclk) begin
        cycles++;
        if (cycles > 3000) begin
            fail_count++;
            final_report();
        end
    end
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= HTRANS_NONSEQ;
        hwrite <= w;
        haddr <= {24'h0, a};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask : xfer
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic wait_idle();
        q = 32'h1;
        while (q[STATE_BUSY_BIT] !== 1'b0) xfer(1'b0, ADDR_STATE, 32'h0);
        chk("state", 32'h0, q);
    endtask : wait_idle
    task automatic rot(input logic [15:0] ins, input logic [11:0] ad, input logic [7:0] v,
                       input logic [2:0] fi, input logic [7:0] r, input logic [2:0] fo);
        logic tf;
        tf = ins[DEST_BIT] || ins[15:9] == OPC_FILL;
        xfer(1'b1, ADDR_MEM_PTR, {20'h0, ad});
        xfer(1'b1, ADDR_MEM_DATA, {24'h0, v});
        xfer(1'b1, ADDR_WORK, 32'h5A);
        xfer(1'b1, ADDR_FLAGS, {29'h0, fi});
        xfer(1'b1, ADDR_INSTR, {16'h0, ins});
        @(posedge hclk);
        wait_idle();
        xfer(1'b0, ADDR_FLAGS, 32'h0);
        chk("flags", {29'h0, fo}, q);
        xfer(1'b0, ADDR_WORK, 32'h0);
        chk("work", tf ? 32'h5A : {24'h0, r}, q);
        xfer(1'b0, ADDR_MEM_DATA, 32'h0);
        chk("file", {24'h0, tf ? r : v}, q);
    endtask : rot
    task automatic t_carry();
        xfer(1'b1, ADDR_BANK, 32'h1);
        rot({OPC_RRC, 2'b11, 8'h23}, 12'h123, 8'hAB, 3'b001, 8'hD5, 3'b101);
        rot({OPC_RRC, 2'b01, 8'h23}, 12'h123, 8'h01, 3'b100, 8'h00, 3'b011);
        $display("test carry rotate done");
    endtask : t_carry
    task automatic t_plain();
        xfer(1'b1, ADDR_BANK, 32'h3);
        rot({OPC_RRN, 2'b10, 8'h10}, 12'h010, 8'hD7, 3'b011, 8'hEB, 3'b101);
        rot({OPC_RRN, 2'b00, 8'h70}, 12'hF70, 8'h00, 3'b000, 8'h00, 3'b010);
        $display("test plain rotate done");
    endtask : t_plain
    task automatic t_index();
        xfer(1'b1, ADDR_CTRL, 32'h1);
        xfer(1'b1, ADDR_INDEX, 32'h200);
        rot({OPC_RRN, 2'b10, 8'h5F}, 12'h25F, 8'h02, 3'b000, 8'h01, 3'b000);
        rot({OPC_RRN, 2'b10, 8'h60}, 12'hF60, 8'h02, 3'b000, 8'h01, 3'b000);
        xfer(1'b1, ADDR_CTRL, 32'h0);
        $display("test indexed offset done");
    endtask : t_index
    task automatic t_fill();
        xfer(1'b1, ADDR_BANK, 32'h2);
        rot({OPC_FILL, 1'b1, 8'hFF}, 12'h2FF, 8'h5A, 3'b111, ALL_ONES, 3'b111);
        rot({OPC_FILL, 1'b0, 8'h00}, 12'h000, 8'h00, 3'b010, ALL_ONES, 3'b010);
        $display("test fill done");
    endtask : t_fill
    // An undecoded word must flag itself and leave W and the file alone.
    task automatic t_illegal();
        xfer(1'b1, ADDR_WORK, 32'h66);
        xfer(1'b1, ADDR_INSTR, 32'h0000_0000);
        @(posedge hclk);
        xfer(1'b0, ADDR_STATE, 32'h0);
        chk("illegal", 32'h2, q);
        xfer(1'b0, ADDR_WORK, 32'h0);
        chk("work untouched", 32'h66, q);
        xfer(1'b0, ADDR_MEM_DATA, 32'h0);
        chk("file untouched", 32'hFF, q);
        $display("test undecoded opcode done");
    endtask : t_illegal
    task automatic t_busy();
        xfer(1'b1, ADDR_WORK, 32'h3C);
        xfer(1'b1, ADDR_MEM_PTR, 32'h40);
        xfer(1'b1, ADDR_MEM_DATA, 32'h81);
        xfer(1'b1, ADDR_INSTR, {16'h0, OPC_RRN, 2'b10, 8'h40});
        @(posedge hclk);
        xfer(1'b1, ADDR_WORK, 32'h99);
        xfer(1'b0, ADDR_STATE, 32'h0);
        chk("busy", 32'h1, q);
        wait_idle();
        xfer(1'b0, ADDR_WORK, 32'h0);
        chk("work kept", 32'h3C, q);
        xfer(1'b0, ADDR_MEM_DATA, 32'h0);
        chk("file rotated", 32'hC0, q);
        $display("test busy window done");
    endtask : t_busy
    initial begin
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (2) @(posedge hclk);
        xfer(1'b0, ADDR_FLAGS, 32'h0);
        chk("flags reset", 32'h0, q);
        t_carry();
        t_plain();
        t_index();
        t_fill();
        t_illegal();
        t_busy();
        final_report();
    end
endmodule : rotate_right_and_set_file_ops_test
`default_nettype wire
